// ### bio_logic.sv
// Binary input conditioning, timed logic equations and output relay mapping
`timescale 1ns/100ps
`default_nettype none
`include "bio_cfg.svh"

module bio_logic
	import bio_pkg::*;
#(
	parameter int TICK_CYC = `BIO_TICK_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Field inputs, bit 0 is the breaker position
	input wire logic [10:0] field_in,
	// Protection side signals
	input wire logic [9:0] prot_pickup,
	input wire logic [3:0] prot_flags,
	input wire logic start_timer_done,
	input wire logic restart_timing,
	input wire logic [7:0] thermal_in,
	input wire bio_start_blk_s start_blk_in,
	// Conditioned functions
	output logic breaker_position_input,
	output logic forced_start_signal,
	output logic [7:0] thermal_out,
	output bio_start_blk_s start_blk_out,
	output logic restart_cancel,
	output logic setting_group_two,
	output logic rotor_turning,
	output logic locked_rotor_enable,
	output logic waveform_record_trigger,
	output logic external_acknowledge,
	output logic thermal_reset,
	output logic vdip_start,
	output logic [1:0] trip_wiring_monitor_input,
	// Delayed inputs and their reports
	output logic [9:0] delayed_input_signal,
	output logic alarm_msg,
	output logic alarm_led,
	output logic event_pulse,
	// Equations and relays
	output logic [7:0] eq_out,
	output logic trip_output_relay,
	output logic [3:0] aux_output_relay
);

	// Input selected by a four-bit index; 6 to 10 need the option fitted
	function automatic logic bio_pick(input logic [3:0] idx, input logic [9:0] v,
			input logic opt);
		bio_pick = (idx != 4'h0) && (idx <= 4'hA) && (opt || idx <= 4'h5)
			&& v[idx - 4'h1];
	endfunction : bio_pick

	function automatic logic bio_used(input logic [3:0] idx, input logic opt);
		bio_used = (idx != 4'h0) && (idx <= 4'hA) && (opt || idx <= 4'h5);
	endfunction : bio_used

	// Equation: OR of selected terms or AND of them, each term optionally inverted
	function automatic logic bio_eq(input logic [15:0] ops, input logic [31:0] cfg,
			input logic or_mode);
		logic [15:0] t;
		t = ops ^ cfg[31:16];
		if (or_mode) begin
			bio_eq = |(t & cfg[15:0]);
		end else begin
			bio_eq = (&(t | ~cfg[15:0])) && (|cfg[15:0]);
		end
	endfunction : bio_eq

	logic [10:0] sync1;
	logic [10:0] sync2;
	logic [31:0] ctrl;
	logic [31:0] assign_r;
	logic [9:0] evt;
	logic [31:0] trip_map;
	logic [7:0] eq_mode;
	logic [31:0] aux_map [4];
	logic [14:0] aux_dly [10];
	logic [31:0] eq_mask [8];
	logic [31:0] eq_time [8];
	logic [14:0] aux_cnt [10];
	logic [15:0] eq_cnt [8];
	logic [16:0] ms_cnt;
	logic ms_tick;
	logic [3:0] cs_cnt;
	logic cs_tick;
	logic [9:0] prog;
	logic opt;
	logic grp_in;
	logic wave_in;
	logic ack_in;
	logic thr_in;
	logic vdip_in;
	logic forced_q;
	logic wave_q;
	logic ack_q;
	logic thr_q;
	logic vdip_q;
	logic [9:0] aux_in;
	logic [9:0] delayed_q;
	logic [9:0] rise;
	logic [7:0] eq_raw;
	logic [15:0] ops;
	logic [31:0] src;
	bio_grp_e grp_st;
	logic [4:0] pulse_cnt;
	logic grp_refuse;
	logic wr_en;
	logic rd_ok;
	logic [31:0] rd_val;

	// Two flops on every field input before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 11'h000;
			sync2 <= 11'h000;
		end else begin
			sync1 <= field_in;
			sync2 <= sync1;
		end
	end

	// Function routing from the assignment register; the second trip wiring monitor takes its index from the control register
	assign opt = ctrl[`BIO_CTRL_OPT];
	assign prog = sync2[10:1];
	assign breaker_position_input = sync2[0];
	assign forced_start_signal = bio_pick(assign_r[4*`BIO_F_FORCED +: 4], prog, opt);
	assign grp_in = bio_pick(assign_r[4*`BIO_F_GROUP +: 4], prog, opt);
	assign rotor_turning = bio_pick(assign_r[4*`BIO_F_ROT +: 4], prog, opt);
	assign locked_rotor_enable = bio_used(assign_r[4*`BIO_F_ROT +: 4], opt);
	assign wave_in = bio_pick(assign_r[4*`BIO_F_WAVE +: 4], prog, opt);
	assign ack_in = bio_pick(assign_r[4*`BIO_F_ACK +: 4], prog, opt);
	assign thr_in = bio_pick(assign_r[4*`BIO_F_THRST +: 4], prog, opt);
	assign vdip_in = ctrl[`BIO_CTRL_VDIP] && bio_pick(assign_r[4*`BIO_F_VDIP +: 4], prog, opt);
	assign trip_wiring_monitor_input[0] = bio_pick(assign_r[4*`BIO_F_TWA +: 4], prog, opt);
	assign trip_wiring_monitor_input[1] = bio_pick(ctrl[`BIO_CTRL_TWB +: 4], prog, opt);
	// Inputs 6 to 10 read as idle without the option board
	assign aux_in = prog & {{5{opt}}, 5'h1F};

	// Common millisecond tick and 0.01 s tick derived from it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt <= 17'h00000;
			cs_cnt <= 4'h0;
		end else begin
			ms_cnt <= ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
			if (ms_tick) begin
				cs_cnt <= cs_tick ? 4'h0 : cs_cnt + 4'h1;
			end
		end
	end
	assign ms_tick = (ms_cnt == 17'(TICK_CYC - 1));
	assign cs_tick = ms_tick && (cs_cnt == `BIO_CS_TICKS - 4'h1);

	// Edge memories for one-shot outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			forced_q <= 1'b0;
			wave_q <= 1'b0;
			ack_q <= 1'b0;
			thr_q <= 1'b0;
			vdip_q <= 1'b0;
			delayed_q <= 10'h000;
		end else begin
			forced_q <= forced_start_signal;
			wave_q <= wave_in;
			ack_q <= ack_in;
			thr_q <= thr_in;
			vdip_q <= vdip_in;
			delayed_q <= delayed_input_signal;
		end
	end

	// Forced start: only overrides blocks, clamps the thermal level and cancels restart timing, never closes
	// the breaker; the field must hold it through the start phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thermal_out <= 8'h00;
			start_blk_out <= '0;
			restart_cancel <= 1'b0;
		end else begin
			if (forced_start_signal && !start_timer_done && thermal_in > `BIO_THERM_LIMIT) begin
				thermal_out <= `BIO_THERM_LIMIT;
			end else begin
				thermal_out <= thermal_in;
			end
			start_blk_out <= forced_start_signal ? '0 : start_blk_in;
			restart_cancel <= forced_start_signal && !forced_q && restart_timing;
		end
	end

	// One-cycle pulses on energising edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			waveform_record_trigger <= 1'b0;
			external_acknowledge <= 1'b0;
			thermal_reset <= 1'b0;
			vdip_start <= 1'b0;
		end else begin
			waveform_record_trigger <= wave_in && !wave_q;
			external_acknowledge <= ack_in && !ack_q;
			thermal_reset <= thr_in && !thr_q;
			vdip_start <= vdip_in && !vdip_q;
		end
	end

	// Setting group selection, frozen while any protection stage is picked up
	assign grp_refuse = |prot_pickup;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_st <= GRP_IDLE;
			pulse_cnt <= 5'h00;
			setting_group_two <= 1'b0;
		end else begin
			unique case (grp_st)
				GRP_IDLE: begin
					pulse_cnt <= 5'h00;
					if (grp_in) begin
						grp_st <= GRP_COUNT;
					end
				end
				GRP_COUNT: begin
					if (!grp_in) begin
						grp_st <= GRP_IDLE;
					end else if (pulse_cnt >= `BIO_GRP_PULSE_TICKS) begin
						grp_st <= GRP_HELD;
						if (!ctrl[`BIO_CTRL_LEVEL] && !grp_refuse) begin
							setting_group_two <= !setting_group_two;
						end
					end else if (ms_tick) begin
						pulse_cnt <= pulse_cnt + 5'h01;
					end
				end
				GRP_HELD: begin
					if (!grp_in) begin
						grp_st <= GRP_IDLE;
					end
				end
			endcase
			if (ctrl[`BIO_CTRL_LEVEL] && !grp_refuse) begin
				setting_group_two <= grp_in;
			end
		end
	end

	// Auxiliary delays in 0.01 s steps, cleared the moment the input drops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < 10; k++) begin
				aux_cnt[k] <= 15'h0000;
			end
		end else begin
			for (int k = 0; k < 10; k++) begin
				if (!aux_in[k]) begin
					aux_cnt[k] <= 15'h0000;
				end else if (cs_tick && aux_cnt[k] < `BIO_AUX_MAX) begin
					aux_cnt[k] <= aux_cnt[k] + 15'h0001;
				end
			end
		end
	end
	always_comb begin
		for (int k = 0; k < 10; k++) begin
			delayed_input_signal[k] = aux_in[k] && (aux_cnt[k] >= aux_dly[k]);
		end
	end
	assign rise = delayed_input_signal & ~delayed_q;

	// Expiry reports; a new expiry beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_msg <= 1'b0;
			alarm_led <= 1'b0;
			event_pulse <= 1'b0;
			evt <= 10'h000;
		end else begin
			alarm_msg <= |rise[1:0];
			event_pulse <= |rise;
			if (|rise[1:0]) begin
				alarm_led <= 1'b1;
			end else if (external_acknowledge) begin
				alarm_led <= 1'b0;
			end
			if (wr_en && paddr == `BIO_EVENT) begin
				evt <= (evt & ~pwdata[9:0]) | rise;
			end else begin
				evt <= evt | rise;
			end
		end
	end

	// Equations over breaker, delayed inputs and protection flags
	assign ops = {prot_flags[3:0], delayed_input_signal, breaker_position_input, 1'b0};
	always_comb begin
		for (int e = 0; e < 8; e++) begin
			eq_raw[e] = bio_eq(ops, eq_mask[e], eq_mode[e]);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eq_out <= 8'h00;
			for (int e = 0; e < 8; e++) begin
				eq_cnt[e] <= 16'h0000;
			end
		end else begin
			for (int e = 0; e < 8; e++) begin
				if (eq_raw[e] == eq_out[e]) begin
					eq_cnt[e] <= 16'h0000;
				end else if (eq_cnt[e] >= (eq_raw[e] ? eq_time[e][15:0] : eq_time[e][31:16])) begin
					eq_out[e] <= eq_raw[e];
					eq_cnt[e] <= 16'h0000;
				end else if (cs_tick) begin
					eq_cnt[e] <= eq_cnt[e] + 16'h0001;
				end
			end
		end
	end

	// Relays energise on any assigned source; latching is done downstream
	assign src = {prot_pickup, delayed_input_signal, eq_out, prot_flags};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_output_relay <= 1'b0;
			aux_output_relay <= 4'h0;
		end else begin
			trip_output_relay <= |(src & trip_map);
			for (int r = 0; r < 4; r++) begin
				aux_output_relay[r] <= |(src & aux_map[r]);
			end
		end
	end

	// APB: zero wait states, error on unmapped offsets
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && rd_ok;
	assign pslverr = psel && penable && !rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		rd_val = `BIO_RST_WORD;
		unique case (paddr)
			`BIO_CTRL: rd_val = ctrl;
			`BIO_ASSIGN: rd_val = assign_r;
			`BIO_STATUS: rd_val = {7'h00, trip_output_relay, aux_output_relay, eq_out,
				setting_group_two, breaker_position_input, delayed_input_signal};
			`BIO_EVENT: rd_val = {22'h000000, evt};
			`BIO_TRIPMAP: rd_val = trip_map;
			`BIO_EQMODE: rd_val = {24'h000000, eq_mode};
			default: begin
				rd_ok = 1'b0;
				for (int k = 0; k < 10; k++) begin
					if (paddr == `BIO_AUXDLY_BASE + 12'(4 * k)) begin
						rd_ok = 1'b1;
						rd_val = {17'h00000, aux_dly[k]};
					end
				end
				for (int k = 0; k < 4; k++) begin
					if (paddr == `BIO_AUXMAP_BASE + 12'(4 * k)) begin
						rd_ok = 1'b1;
						rd_val = aux_map[k];
					end
				end
				for (int k = 0; k < 8; k++) begin
					if (paddr == `BIO_EQMASK_BASE + 12'(8 * k)) begin
						rd_ok = 1'b1;
						rd_val = eq_mask[k];
					end else if (paddr == `BIO_EQTIME_BASE + 12'(8 * k)) begin
						rd_ok = 1'b1;
						rd_val = eq_time[k];
					end
				end
			end
		endcase
	end

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `BIO_RST_WORD;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_val;
		end
	end

	// Register writes; delays above their range are clamped to the maximum
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `BIO_RST_WORD;
			assign_r <= `BIO_RST_WORD;
			trip_map <= `BIO_RST_WORD;
			eq_mode <= 8'h00;
			for (int k = 0; k < 10; k++) begin
				aux_dly[k] <= 15'h0000;
			end
			for (int k = 0; k < 4; k++) begin
				aux_map[k] <= `BIO_RST_WORD;
			end
			for (int k = 0; k < 8; k++) begin
				eq_mask[k] <= `BIO_RST_WORD;
				eq_time[k] <= `BIO_RST_WORD;
			end
		end else if (wr_en) begin
			if (paddr == `BIO_CTRL) begin
				ctrl <= pwdata;
			end
			if (paddr == `BIO_ASSIGN) begin
				assign_r <= pwdata;
			end
			if (paddr == `BIO_TRIPMAP) begin
				trip_map <= pwdata;
			end
			if (paddr == `BIO_EQMODE) begin
				eq_mode <= pwdata[7:0];
			end
			for (int k = 0; k < 10; k++) begin
				if (paddr == `BIO_AUXDLY_BASE + 12'(4 * k)) begin
					aux_dly[k] <= (pwdata[31:15] != 17'h00000 || pwdata[14:0] > `BIO_AUX_MAX)
						? `BIO_AUX_MAX : pwdata[14:0];
				end
			end
			for (int k = 0; k < 4; k++) begin
				if (paddr == `BIO_AUXMAP_BASE + 12'(4 * k)) begin
					aux_map[k] <= pwdata;
				end
			end
			for (int k = 0; k < 8; k++) begin
				if (paddr == `BIO_EQMASK_BASE + 12'(8 * k)) begin
					eq_mask[k] <= pwdata;
				end
				if (paddr == `BIO_EQTIME_BASE + 12'(8 * k)) begin
					eq_time[k][15:0] <= (pwdata[15:0] > `BIO_EQ_MAX) ? `BIO_EQ_MAX : pwdata[15:0];
					eq_time[k][31:16] <= (pwdata[31:16] > `BIO_EQ_MAX) ? `BIO_EQ_MAX
						: pwdata[31:16];
				end
			end
		end
	end

	// Checks
	sequence forced_rise_s;
		$rose(forced_start_signal) && restart_timing;
	endsequence
	breaker_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		breaker_position_input == $past(field_in[0], 2)) else $error("breaker lag wrong");
	therm_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
		forced_start_signal && !start_timer_done |=> thermal_out <= 8'h5A)
		else $error("thermal above clamp");
	start_blk_a: assert property (@(posedge pclk) disable iff (!presetn)
		forced_start_signal |=> start_blk_out == '0) else $error("start block kept");
	restart_cut_a: assert property (@(posedge pclk) disable iff (!presetn)
		forced_rise_s |=> restart_cancel) else $error("restart not cancelled");
	group_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		grp_refuse |=> $stable(setting_group_two)) else $error("group changed in pickup");
	group_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[1] && !grp_refuse |=> setting_group_two == $past(grp_in))
		else $error("level group wrong");
	record_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		waveform_record_trigger |-> $past(wave_in) && !$past(wave_q) ##1 !waveform_record_trigger)
		else $error("record trigger not an edge");
	aux_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		!aux_in[0] |-> !delayed_input_signal[0]) else $error("delayed signal stuck");
	aux_only_event_a: assert property (@(posedge pclk) disable iff (!presetn)
		event_pulse && !$past(|rise[1:0]) |-> !alarm_msg) else $error("alarm from late aux");
	aux_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(delayed_input_signal[0]) |=> alarm_msg && event_pulse && alarm_led)
		else $error("aux one alarm missing");
	ack_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		external_acknowledge && !(|rise[1:0]) |=> !alarm_led) else $error("alarm not cleared");
	trip_or_a: assert property (@(posedge pclk) disable iff (!presetn)
		trip_output_relay == $past(|(src & trip_map))) else $error("trip relay mismatch");

endmodule : bio_logic
`default_nettype wire

// ### bio_cfg.svh
// Offsets, field positions, reset values and timing counts of the binary I/O block
`ifndef BIO_CFG_SVH
`define BIO_CFG_SVH
// Clock and common time base
`define BIO_CLK_NS 8
`define BIO_TICK_NS 1000000
`define BIO_TICK_CYC (`BIO_TICK_NS / `BIO_CLK_NS)
`define BIO_CS_TICKS 4'hA
`define BIO_GRP_PULSE_MS 15
`define BIO_GRP_PULSE_TICKS 5'((`BIO_GRP_PULSE_MS * 1000000 + `BIO_TICK_NS - 1) / `BIO_TICK_NS)
// Limits, in percent and in 0.01 s steps
`define BIO_THERM_LIMIT 8'h5A
`define BIO_AUX_MAX 15'h4E20
`define BIO_EQ_MAX 16'hEA60
// Register offsets
`define BIO_CTRL 12'h000
`define BIO_ASSIGN 12'h004
`define BIO_STATUS 12'h008
`define BIO_EVENT 12'h00C
`define BIO_TRIPMAP 12'h010
`define BIO_EQMODE 12'h014
`define BIO_AUXMAP_BASE 12'h020
`define BIO_AUXDLY_BASE 12'h040
`define BIO_EQMASK_BASE 12'h080
`define BIO_EQTIME_BASE 12'h084
// Control fields
`define BIO_CTRL_OPT 0
`define BIO_CTRL_LEVEL 1
`define BIO_CTRL_VDIP 2
`define BIO_CTRL_TWB 4
// Function slots in the assignment register, four bits each
`define BIO_F_FORCED 0
`define BIO_F_GROUP 1
`define BIO_F_ROT 2
`define BIO_F_WAVE 3
`define BIO_F_ACK 4
`define BIO_F_THRST 5
`define BIO_F_VDIP 6
`define BIO_F_TWA 7
`define BIO_RST_WORD 32'h0000_0000
`endif

// ### bio_pkg.sv
// Types shared by the binary I/O block
package bio_pkg;
	// Start blocking signals that a forced start overrides
	typedef struct packed {
		logic heat_start_inhibit;
		logic start_count_block;
		logic min_gap_block;
		logic reverse_spin_block;
	} bio_start_blk_s;
	// Pulse-mode setting group selector
	typedef enum logic [2:0] {
		GRP_IDLE = 3'b001,
		GRP_COUNT = 3'b010,
		GRP_HELD = 3'b100
	} bio_grp_e;
endpackage : bio_pkg

// ### bio_field_model.sv
// Field contacts and breaker auxiliary contact feeding the binary inputs
`timescale 1ns/100ps
`default_nettype none

module bio_field_model (
	// Contact states set by the bench
	input wire logic breaker_closed,
	input wire logic [10:1] contact_closed,
	// Pins toward the block
	output logic [10:0] field_in
);
	// Breaker contact is always wired, so the pin is never left floating
	assign field_in[0] = breaker_closed;
	// Forced start and rotation contacts are held for whole phases
	assign field_in[10:1] = contact_closed;
endmodule : bio_field_model
`default_nettype wire

// ### binary_input_output_logic_bench.sv
// Self-checking bench for the binary I/O block and its field contacts
`timescale 1ns/100ps
`default_nettype none
`include "bio_cfg.svh"

module binary_input_output_logic_bench import bio_pkg::*; ();
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rde, breaker;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic [10:0] field_in;
	logic [10:1] contact;
	logic [9:0] prot_pickup, delayed_input_signal;
	logic [3:0] prot_flags, aux_output_relay;
	logic [7:0] thermal_in, thermal_out, eq_out;
	logic [1:0] trip_wiring_monitor_input;
	logic start_timer_done, restart_timing, breaker_position_input, forced_start_signal;
	logic restart_cancel, setting_group_two, rotor_turning, locked_rotor_enable;
	logic waveform_record_trigger, external_acknowledge, thermal_reset, vdip_start;
	logic alarm_msg, alarm_led, event_pulse, trip_output_relay;
	bio_start_blk_s start_blk_in, start_blk_out;
	int num_errors = 0, total_checks = 0, n_can = 0, n_wav = 0, n_ack = 0;
	int n_trs = 0, n_vd = 0, n_am = 0, n_ev = 0;

	// Short tick keeps 0.01 s steps to 100 cycles
	bio_logic #(.TICK_CYC(10)) bio_logic_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .field_in, .prot_pickup, .prot_flags, .start_timer_done,
		.restart_timing, .thermal_in, .start_blk_in, .breaker_position_input,
		.forced_start_signal, .thermal_out, .start_blk_out, .restart_cancel,
		.setting_group_two, .rotor_turning, .locked_rotor_enable,
		.waveform_record_trigger, .external_acknowledge, .thermal_reset, .vdip_start,
		.trip_wiring_monitor_input, .delayed_input_signal, .alarm_msg, .alarm_led,
		.event_pulse, .eq_out, .trip_output_relay, .aux_output_relay);

	bio_field_model bio_field_model_inst (
		.breaker_closed(breaker), .contact_closed(contact), .field_in(field_in));

	// Clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Count pulse outputs so single-cycle events are never missed
	always @(posedge pclk) begin
		if (restart_cancel === 1'b1) n_can++;
		if (waveform_record_trigger === 1'b1) n_wav++;
		if (external_acknowledge === 1'b1) n_ack++;
		if (thermal_reset === 1'b1) n_trs++;
		if (vdip_start === 1'b1) n_vd++;
		if (alarm_msg === 1'b1) n_am++;
		if (event_pulse === 1'b1) n_ev++;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Let outputs settle past the edge before sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	// One APB transfer; waits on pready, only the watchdog ends a hung wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdq = prdata;
		rde = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task automatic t_regs();
		rd(`BIO_CTRL);
		chk(rdq, `BIO_RST_WORD);
		rd(12'hFFC);
		chk({rdq[30:0], rde}, 32'h1);
		wr(`BIO_AUXDLY_BASE, 32'h3);
		wr(`BIO_AUXDLY_BASE + 12'h004, 32'hFFFF);
		wr(`BIO_AUXDLY_BASE + 12'h008, 32'h2);
		rd(`BIO_AUXDLY_BASE + 12'h004);
		chk(rdq, {17'h0, `BIO_AUX_MAX});
		wr(`BIO_ASSIGN, 32'h0657_4321);
		@(posedge pclk);
		breaker <= 1'b1;
		cyc(4);
		chk(breaker_position_input, 1'b1);
		rd(`BIO_STATUS);
		chk(rdq[10], 1'b1);
		@(posedge pclk);
		breaker <= 1'b0;
		cyc(4);
		chk(breaker_position_input, 1'b0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_forced();
		@(posedge pclk);
		thermal_in <= 8'hC8;
		start_blk_in <= 4'hF;
		restart_timing <= 1'b1;
		contact[1] <= 1'b1;
		cyc(5);
		chk(forced_start_signal, 1'b1);
		chk(thermal_out, `BIO_THERM_LIMIT);
		chk(start_blk_out, 4'h0);
		chk(n_can, 1);
		chk({trip_output_relay, aux_output_relay}, 5'h0);
		@(posedge pclk);
		start_timer_done <= 1'b1;
		cyc(4);
		chk(thermal_out, 8'hC8);
		@(posedge pclk);
		contact[1] <= 1'b0;
		restart_timing <= 1'b0;
		cyc(5);
		chk(start_blk_out, 4'hF);
		$display("test forced done");
	endtask : t_forced

	task automatic pulse2(input int n);
		@(posedge pclk);
		contact[2] <= 1'b1;
		repeat (n) @(posedge pclk);
		contact[2] <= 1'b0;
		cyc(5);
	endtask : pulse2

	task automatic t_group();
		wr(`BIO_CTRL, 32'h3);
		pulse2(5);
		chk(setting_group_two, 1'b0);
		@(posedge pclk);
		contact[2] <= 1'b1;
		cyc(5);
		chk(setting_group_two, 1'b1);
		@(posedge pclk);
		prot_pickup <= 10'h200;
		contact[2] <= 1'b0;
		cyc(5);
		chk(setting_group_two, 1'b1);
		@(posedge pclk);
		prot_pickup <= 10'h0;
		cyc(5);
		chk(setting_group_two, 1'b0);
		wr(`BIO_CTRL, 32'h1);
		pulse2(100);
		chk(setting_group_two, 1'b0);
		pulse2(200);
		chk(setting_group_two, 1'b1);
		$display("test group done");
	endtask : t_group

	task automatic t_pulses();
		wr(`BIO_CTRL, 32'h35); // Second trip wiring monitor on input 3
		@(posedge pclk);
		contact[6:3] <= 4'hF;
		cyc(10);
		chk({n_wav[3:0], n_trs[3:0], n_vd[3:0]}, 12'h111);
		chk({rotor_turning, locked_rotor_enable}, 2'b11);
		chk(trip_wiring_monitor_input, 2'b10);
		@(posedge pclk);
		contact[6:3] <= 4'h0;
		cyc(4);
		chk(rotor_turning, 1'b0);
		chk(trip_wiring_monitor_input, 2'b00);
		wr(`BIO_ASSIGN, 32'h0657_4021);
		cyc(2);
		chk(locked_rotor_enable, 1'b0);
		$display("test pulses done");
	endtask : t_pulses

	task automatic t_delay();
		int ev0;
		wr(`BIO_CTRL, 32'h0);
		wr(`BIO_EVENT, 32'h3FF);
		ev0 = n_ev;
		@(posedge pclk);
		contact[3] <= 1'b1;
		cyc(90);
		chk(delayed_input_signal[2], 1'b0);
		cyc(220);
		chk(delayed_input_signal[2], 1'b1);
		chk({alarm_led, n_am[3:0]}, 5'h0);
		rd(`BIO_EVENT);
		chk(rdq, 32'h4);
		chk(n_ev - ev0, 1);
		@(posedge pclk);
		contact[1] <= 1'b1;
		cyc(410);
		chk(delayed_input_signal[0], 1'b1);
		chk({alarm_led, n_am[3:0]}, 5'h11);
		rd(`BIO_EVENT);
		chk(rdq, 32'h5);
		chk(n_ev - ev0, 2);
		@(posedge pclk);
		contact[1] <= 1'b0;
		contact[7] <= 1'b1;
		cyc(3);
		chk(delayed_input_signal[0], 1'b0);
		chk({alarm_led, n_ack[3:0]}, 5'h10);
		@(posedge pclk);
		contact[7] <= 1'b0;
		cyc(3);
		wr(`BIO_CTRL, 32'h1);
		@(posedge pclk);
		contact[7] <= 1'b1;
		cyc(5);
		chk({alarm_led, n_ack[3:0]}, 5'h01);
		$display("test delay done");
	endtask : t_delay

	task automatic t_eq();
		wr(`BIO_EQMODE, 32'h2);
		wr(`BIO_EQMASK_BASE, 32'h2);
		wr(`BIO_EQTIME_BASE, 32'h2);
		wr(`BIO_EQMASK_BASE + 12'h008, 32'h0002_0002);
		wr(`BIO_TRIPMAP, 32'h11);
		wr(`BIO_AUXMAP_BASE, 32'h20);
		cyc(4);
		chk({eq_out[1], aux_output_relay[0]}, 2'b11);
		@(posedge pclk);
		breaker <= 1'b1;
		cyc(50);
		chk({eq_out[1:0], trip_output_relay}, 3'b000);
		cyc(260);
		chk({eq_out[0], trip_output_relay}, 2'b11);
		@(posedge pclk);
		breaker <= 1'b0;
		prot_flags <= 4'h1;
		cyc(5);
		chk({eq_out[0], trip_output_relay}, 2'b01);
		$display("test eq done");
	endtask : t_eq

	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : print_verdict

	// Hang guard, about twenty times the expected run
	initial begin
		#(8 * 30000);
		num_errors++;
		$display("ERROR t=%0t watchdog expired", $time);
		print_verdict();
	end

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, breaker, start_timer_done, restart_timing} = 7'h0;
		{paddr, pwdata, contact, prot_pickup, prot_flags, thermal_in} = '0;
		start_blk_in = 4'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_forced();
		t_group();
		t_pulses();
		t_delay();
		t_eq();
		print_verdict();
	end
endmodule : binary_input_output_logic_bench
`default_nettype wire
